// file: verilog/odc_decoder.sv
// Serial frame receiver, chain output and command decoder for 8 channels
`timescale 1ns/1ps
module odc_decoder
  import odc_pkg::*;
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Serial link
  input wire logic shift_clk,
  input wire logic frame_sel_n,
  input wire logic serial_in,
  output logic chain_out,
  // Channel state
  output logic [NUM_CHAN-1:0][VALUE_BITS-1:0] chan_out,
  output logic [NUM_CHAN-1:0][VALUE_BITS-1:0] chan_data,
  output logic [NUM_CHAN-1:0][PD_BITS-1:0] chan_pd,
  // Status
  output logic immediate_mode,
  output logic frame_done,
  output logic frame_abort,
  output logic [WORD_BITS-1:0] last_word
);

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_SETTLE} odc_state_t;

  // Link domain state
  logic link_rst;
  logic [CNT_BITS-1:0] cnt_q;
  logic [WORD_BITS-1:0] shift_q;
  logic chain_q;
  logic start_tag_q;
  logic done_tag_q;

  // System domain state
  logic sel_meta_q;
  logic sel_sync_q;
  logic [WORD_BITS-1:0] word_meta_q;
  logic [WORD_BITS-1:0] word_sync_q;
  logic start_meta_q;
  logic start_sync_q;
  logic done_meta_q;
  logic done_sync_q;
  logic seen_tag_q;
  odc_state_t state_q;
  logic exec_q;
  logic abort_q;
  logic [WORD_BITS-1:0] last_q;
  logic mode_q;
  logic valid_frame;

  // Decoded strobes toward the channels
  logic [NUM_CHAN-1:0] load_q;
  logic [NUM_CHAN-1:0] update_q;
  logic [NUM_CHAN-1:0] pd_req_q;
  logic [PD_BITS-1:0] pd_code_q;
  logic [VALUE_BITS-1:0] value_q;

  odc_cmd_t cmd;
  logic [SEL_BITS-1:0] sel;
  logic [NUM_CHAN-1:0] mask;

  function automatic odc_cmd_t decode_cmd(input logic [3:0] nib);
    odc_cmd_t c;
    c = CMD_WRITE;
    if (nib[3]) begin
      unique case (nib)
        NIB_STAGED: c = CMD_STAGED;
        NIB_IMMED: c = CMD_IMMED;
        NIB_SELUPD: c = CMD_SELUPD;
        NIB_FIRST: c = CMD_FIRST;
        NIB_BCAST: c = CMD_BCAST;
        NIB_PD_HIZ: c = CMD_PD_HIZ;
        NIB_PD_MID: c = CMD_PD_MID;
        default: c = CMD_PD_LOW;
      endcase
    end
    return c;
  endfunction : decode_cmd

  // Counter and chain output are held cleared while the frame select is high
  assign link_rst = reset | frame_sel_n;

  // Falling-edge counter, saturating
  always_ff @(negedge shift_clk or posedge link_rst) begin
    if (link_rst) begin
      cnt_q <= CNT_ZERO;
    end else if (cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Input shift register, newest bit at the bottom
  always_ff @(negedge shift_clk or posedge reset) begin
    if (reset) begin
      shift_q <= WORD_ZERO;
    end else if (!frame_sel_n) begin
      // Only bits taken inside a frame count
      shift_q <= {shift_q[WORD_BITS-2:0], serial_in};
    end
  end

  // Chain output
  always_ff @(negedge shift_clk or posedge link_rst) begin
    if (link_rst) begin
      chain_q <= 1'b0;
    end else if (cnt_q < CHAIN_LOW_EDGES) begin
      chain_q <= 1'b0;
    end else if (cnt_q == CHAIN_LOW_EDGES) begin
      chain_q <= 1'b1;
    end else begin
      chain_q <= shift_q[CHAIN_TAP];
    end
  end

  // Frame tags: start toggles on the first edge, done copies it on the
  // fifteenth, so a frame with too few edges leaves them unequal
  always_ff @(negedge shift_clk or posedge reset) begin
    if (reset) begin
      start_tag_q <= 1'b0;
    end else if (!frame_sel_n && cnt_q == CNT_ZERO) begin
      start_tag_q <= ~start_tag_q;
    end
  end

  always_ff @(negedge shift_clk or posedge reset) begin
    if (reset) begin
      done_tag_q <= 1'b0;
    end else if (!frame_sel_n && cnt_q == CHAIN_LOW_EDGES) begin
      done_tag_q <= start_tag_q;
    end
  end

  // Synchronisers; word and tags are static while select is high
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sel_meta_q <= 1'b1;
      sel_sync_q <= 1'b1;
    end else begin
      sel_meta_q <= frame_sel_n;
      sel_sync_q <= sel_meta_q;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      word_meta_q <= WORD_ZERO;
      word_sync_q <= WORD_ZERO;
      start_meta_q <= 1'b0;
      start_sync_q <= 1'b0;
      done_meta_q <= 1'b0;
      done_sync_q <= 1'b0;
    end else begin
      word_meta_q <= shift_q;
      word_sync_q <= word_meta_q;
      start_meta_q <= start_tag_q;
      start_sync_q <= start_meta_q;
      done_meta_q <= done_tag_q;
      done_sync_q <= done_meta_q;
    end
  end

  assign valid_frame = (done_sync_q == start_sync_q) &&
                       (start_sync_q != seen_tag_q);

  // Frame tracking
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (!sel_sync_q) begin
            state_q <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (sel_sync_q) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          state_q <= ST_IDLE;
        end
        // Unused code falls back to idle
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seen_tag_q <= 1'b0;
    end else if (state_q == ST_SETTLE) begin
      seen_tag_q <= start_sync_q;
    end
  end

  // Execute or abort one cycle after the select rise is seen
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      exec_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      exec_q <= (state_q == ST_SETTLE) && valid_frame;
      abort_q <= (state_q == ST_SETTLE) && !valid_frame;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      last_q <= WORD_ZERO;
    end else if (state_q == ST_SETTLE && valid_frame) begin
      last_q <= word_sync_q;
    end
  end

  // Fields of the executed word
  assign cmd = decode_cmd(last_q[CMD_MSB:CMD_LSB]);
  assign sel = last_q[SEL_MSB:SEL_LSB];
  assign mask = last_q[MASK_MSB:0];

  // Mode register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_q <= 1'b0;
    end else if (exec_q) begin
      unique case (cmd)
        CMD_STAGED: mode_q <= 1'b0;
        CMD_IMMED: mode_q <= 1'b1;
        default: mode_q <= mode_q;
      endcase
    end
  end

  // Register load strobes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      load_q <= '0;
      value_q <= VALUE_ZERO;
    end else begin
      load_q <= '0;
      value_q <= last_q[VALUE_MSB:0];
      if (exec_q) begin
        unique case (cmd)
          CMD_WRITE: load_q[sel] <= 1'b1;
          CMD_FIRST: load_q[0] <= 1'b1;
          CMD_BCAST: load_q <= '1;
          default: load_q <= '0;
        endcase
      end
    end
  end

  // Output update strobes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      update_q <= '0;
    end else begin
      update_q <= '0;
      if (exec_q) begin
        unique case (cmd)
          CMD_WRITE: update_q[sel] <= mode_q;
          CMD_SELUPD: update_q <= mask;
          CMD_FIRST: update_q <= '1;
          CMD_BCAST: update_q <= '1;
          default: update_q <= '0;
        endcase
      end
    end
  end

  // Power-down strobes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pd_req_q <= '0;
      pd_code_q <= PD_ACTIVE;
    end else begin
      pd_req_q <= '0;
      if (exec_q) begin
        unique case (cmd)
          CMD_PD_HIZ: begin
            pd_req_q <= mask;
            pd_code_q <= PD_HIZ;
          end
          CMD_PD_MID: begin
            pd_req_q <= mask;
            pd_code_q <= PD_MID;
          end
          CMD_PD_LOW: begin
            pd_req_q <= mask;
            pd_code_q <= PD_LOW;
          end
          default: pd_req_q <= '0;
        endcase
      end
    end
  end

  // Channels
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    odc_chan_if ch_if ();
    assign ch_if.load = load_q[i];
    assign ch_if.update = update_q[i];
    assign ch_if.pd_req = pd_req_q[i];
    assign ch_if.pd_code = pd_code_q;
    assign ch_if.value = value_q;
    odc_channel u_chan (
      .ref_clk(ref_clk),
      .reset(reset),
      .ch(ch_if.chan)
    );
    assign chan_out[i] = ch_if.out;
    assign chan_data[i] = ch_if.data;
    assign chan_pd[i] = ch_if.pd;
  end

  assign chain_out = chain_q;
  assign immediate_mode = mode_q;
  assign frame_done = exec_q;
  assign frame_abort = abort_q;
  assign last_word = last_q;

endmodule : odc_decoder

// file: verilog/odc_pkg.sv
// Constants and types shared by the serial command decoder files
package odc_pkg;

  localparam int WORD_BITS = 16;
  localparam int VALUE_BITS = 12;
  localparam int NUM_CHAN = 8;
  localparam int SEL_BITS = 3;
  localparam int PD_BITS = 2;
  localparam int CNT_BITS = 5;

  // Edge counts within one frame
  localparam logic [CNT_BITS-1:0] CNT_MAX = 5'h1f;
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_BITS-1:0] CHAIN_LOW_EDGES = 5'h0e;
  localparam logic [CNT_BITS-1:0] CHAIN_PASS_EDGES = 5'h0f;

  // Field positions in the 16-bit word
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int WRITE_FLAG_BIT = 15;
  localparam int SEL_MSB = 14;
  localparam int SEL_LSB = 12;
  localparam int VALUE_MSB = 11;
  localparam int MASK_MSB = 7;
  localparam int CHAIN_TAP = 14;

  // Command nibbles
  localparam logic [3:0] NIB_STAGED = 4'h8;
  localparam logic [3:0] NIB_IMMED = 4'h9;
  localparam logic [3:0] NIB_SELUPD = 4'ha;
  localparam logic [3:0] NIB_FIRST = 4'hb;
  localparam logic [3:0] NIB_BCAST = 4'hc;
  localparam logic [3:0] NIB_PD_HIZ = 4'hd;
  localparam logic [3:0] NIB_PD_MID = 4'he;
  localparam logic [3:0] NIB_PD_LOW = 4'hf;

  // Output termination codes
  localparam logic [PD_BITS-1:0] PD_ACTIVE = 2'h0;
  localparam logic [PD_BITS-1:0] PD_HIZ = 2'h1;
  localparam logic [PD_BITS-1:0] PD_MID = 2'h2;
  localparam logic [PD_BITS-1:0] PD_LOW = 2'h3;

  localparam logic [VALUE_BITS-1:0] VALUE_ZERO = 12'h000;
  localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    CMD_WRITE, CMD_STAGED, CMD_IMMED, CMD_SELUPD, CMD_FIRST,
    CMD_BCAST, CMD_PD_HIZ, CMD_PD_MID, CMD_PD_LOW
  } odc_cmd_t;

endpackage : odc_pkg

// file: verilog/odc_chan_if.sv
// Strobes and state passed between the decoder and one channel
`timescale 1ns/1ps
interface odc_chan_if;
  import odc_pkg::*;
  logic load;
  logic update;
  logic pd_req;
  logic [PD_BITS-1:0] pd_code;
  logic [VALUE_BITS-1:0] value;
  logic [VALUE_BITS-1:0] data;
  logic [VALUE_BITS-1:0] out;
  logic [PD_BITS-1:0] pd;
  modport ctrl (output load, update, pd_req, pd_code, value,
                input data, out, pd);
  modport chan (input load, update, pd_req, pd_code, value,
                output data, out, pd);
endinterface : odc_chan_if

// file: verilog/odc_channel.sv
// One converter channel: data register, output latch, power-down state
`timescale 1ns/1ps
module odc_channel
  import odc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Decoder side
  odc_chan_if.chan ch
);

  logic [VALUE_BITS-1:0] data_q;
  logic [VALUE_BITS-1:0] out_q;
  logic [PD_BITS-1:0] pd_q;

  // Data register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      data_q <= VALUE_ZERO;
    end else if (ch.load) begin
      data_q <= ch.value;
    end
  end

  // Output latch, new value wins when loaded in the same step
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      out_q <= VALUE_ZERO;
    end else if (ch.update) begin
      out_q <= ch.load ? ch.value : data_q;
    end
  end

  // Power-down keeps the registers, an output update wakes the channel
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pd_q <= PD_ACTIVE;
    end else if (ch.update) begin
      pd_q <= PD_ACTIVE;
    end else if (ch.pd_req) begin
      pd_q <= ch.pd_code;
    end
  end

  assign ch.data = data_q;
  assign ch.out = out_q;
  assign ch.pd = pd_q;

endmodule : odc_channel

// file: test/odc_host_model.sv
// Host serial controller model driving frame select, shift clock, data
`timescale 1ns/1ps
module odc_host_model (
  // Link towards the device
  output logic shift_clk,
  output logic frame_sel_n,
  output logic serial_in,
  // Chain output of the device
  input wire logic chain_out
);
  logic [31:0] cap_q;

  initial begin
    shift_clk = 1'b1;
    frame_sel_n = 1'b1;
    serial_in = 1'b0;
    cap_q = 32'h0;
  end

  // Chain output is taken before the next falling edge
  always @(posedge shift_clk) begin
    cap_q <= {cap_q[30:0], chain_out};
  end

  // Clock stands still between frames; data flips after release
  task send(input logic [31:0] w, input int n);
    frame_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #80 shift_clk = 1'b1;
      serial_in = w[i];
      #80 shift_clk = 1'b0;
    end
    #80 shift_clk = 1'b1;
    #80 frame_sel_n = 1'b1;
    serial_in = ~serial_in;
    #400;
  endtask : send
endmodule : odc_host_model

// file: test/odc_decoder_asserts.sv
// Concurrent checks on the serial command decoder ports
`timescale 1ns/1ps
module odc_decoder_asserts
  import odc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Link
  input wire logic frame_sel_n,
  input wire logic chain_out,
  // Channel state and status
  input wire logic [NUM_CHAN-1:0][VALUE_BITS-1:0] chan_out,
  input wire logic [NUM_CHAN-1:0][VALUE_BITS-1:0] chan_data,
  input wire logic immediate_mode,
  input wire logic frame_done,
  input wire logic frame_abort,
  input wire logic [WORD_BITS-1:0] last_word
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  done_excl_a: assert property (
    !(frame_done && frame_abort)) else $error("done with abort");
  done_pulse_a: assert property (
    frame_done |=> !frame_done) else $error("done too long");
  exec_time_a: assert property (
    $rose(frame_sel_n) |-> ##[1:6] (frame_done || frame_abort))
    else $error("frame end missing");
  data_time_a: assert property (
    !$stable(chan_data) |-> $past(frame_done, 2))
    else $error("data changed off time");
  out_time_a: assert property (
    !$stable(chan_out) |-> $past(frame_done, 2))
    else $error("output changed off time");
  mode_time_a: assert property (
    !$stable(immediate_mode) |-> $past(frame_done) || $past(frame_done, 2))
    else $error("mode changed off time");
  abort_hold_a: assert property (
    frame_abort |=> ($stable(chan_data) && $stable(chan_out)
    && $stable(immediate_mode) && $stable(last_word))[*4])
    else $error("abort changed state");
  chain_idle_a: assert property (
    frame_sel_n && $past(frame_sel_n) |-> !chain_out)
    else $error("chain output high outside frame");
endmodule : odc_decoder_asserts

bind odc_decoder odc_decoder_asserts i_odc_decoder_asserts (
  .ref_clk, .reset, .frame_sel_n, .chain_out, .chan_out, .chan_data,
  .immediate_mode, .frame_done, .frame_abort, .last_word);

// file: test/testbench.sv
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
module testbench;
  import odc_pkg::*;
  typedef struct packed {
    logic ab;
    logic [15:0] w;
    logic imm;
    logic [7:0][11:0] o;
    logic [7:0][11:0] d;
    logic [7:0][1:0] p;
  } odc_note_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b0;
  logic shift_clk, frame_sel_n, serial_in, chain_out, immediate_mode;
  logic frame_done, frame_abort;
  logic [15:0] last_word, r;
  logic [7:0][11:0] chan_out, chan_data;
  logic [7:0][1:0] chan_pd;
  logic [31:0] ww;
  odc_note_t m, q[$];
  int err_total = 0;
  int n_compared = 0;
  logic [15:0] lfsr = 16'h0024;

  always #25 ref_clk = ~ref_clk;

  odc_decoder i_odc_decoder (.ref_clk, .reset, .shift_clk, .frame_sel_n,
    .serial_in, .chain_out, .chan_out, .chan_data, .chan_pd,
    .immediate_mode, .frame_done, .frame_abort, .last_word);
  odc_host_model i_odc_host_model (.shift_clk, .frame_sel_n, .serial_in,
    .chain_out);

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task chk(input logic [95:0] s, input logic [95:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task upd(input int i);
    m.o[i] = m.d[i];
    m.p[i] = 2'h0;
  endtask : upd

  // Works out the expected state, notes it, then sends the frame
  task run(input logic [31:0] w, input int n);
    logic [15:0] c;
    c = w[15:0];
    m.ab = n < 15;
    if (!m.ab) begin
      m.w = c;
      if (c[15:12] == 4'hb) m.d[0] = c[11:0];
      for (int i = 0; i < 8; i++) begin
        case (c[15:12])
          4'h8: m.imm = 1'b0;
          4'h9: m.imm = 1'b1;
          4'ha: if (c[i]) upd(i);
          4'hb: upd(i);
          4'hc: begin
            m.d[i] = c[11:0];
            upd(i);
          end
          4'hd, 4'he, 4'hf: if (c[i]) m.p[i] = c[13:12];
          default: if (i == c[14:12]) begin
            m.d[i] = c[11:0];
            if (m.imm) upd(i);
          end
        endcase
      end
    end
    q.push_back(m);
    @(negedge ref_clk);
    i_odc_host_model.send(w, n);
  endtask : run

  task final_report();
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Takes the oldest note whenever a frame ends
  initial begin
    odc_note_t e;
    forever begin
      @(negedge ref_clk);
      if (frame_done === 1'b1 || frame_abort === 1'b1) begin
        e = q.pop_front();
        chk(frame_abort, e.ab);
        if (!e.ab) chk(last_word, e.w);
        repeat (3) @(negedge ref_clk);
        chk(chan_out, e.o);
        chk(chan_data, e.d);
        chk(chan_pd, e.p);
        chk(immediate_mode, e.imm);
      end
    end
  end

  initial begin
    m = '0;
    // A real reset edge also clears flops on the idle link clock
    #1 reset = 1'b1;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    chk(chan_out, 96'h0);
    chk(chan_data, 96'h0);
    chk(immediate_mode, 1'b0);
    for (int c = 0; c < 8; c++) begin
      r = rnd();
      run({17'h0, c[2:0], r[11:0]}, 16);
    end
    r = rnd();
    run({16'h0, 4'ha, r[3:0], 8'h5a}, 16);
    run({16'h0, 4'h9, r[11:0]}, 16);
    r = rnd();
    run({16'h0, 4'h6, r[11:0]}, 16);
    run({16'h0, 4'hb, r[11:0]}, 16);
    run({16'h0, 4'h8, r[11:0]}, 16);
    r = rnd();
    run({16'h0, 4'hb, r[11:0]}, 16);
    for (int k = 13; k < 16; k++) begin
      r = rnd();
      run({16'h0, k[3:0], r[11:0]}, 16);
    end
    run({16'h0, 4'hc, r[11:0]}, 16);
    run({rnd(), rnd()}, 14);
    ww = {rnd(), rnd()};
    run(ww, 32);
    chk(i_odc_host_model.cap_q, {14'h0, 1'b1, ww[31:15]});
    wait (q.size() == 0);
    repeat (6) @(negedge ref_clk);
    final_report();
  end

  initial begin
    #300000;
    err_total++;
    final_report();
  end
endmodule : testbench
